// ==== logic/rssc_ctrl.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - Below reset level, charge with limited current.
// - After start level, hysteretic start-up switch control.
// - Protection state keeps hysteretic aux regulation.
// - Burst idle: charge below low threshold, hysteresis.
// - No switching until driver supply above UVP.
// - Either supply below stop: no-supply, recharge.
// - At start levels, read resistor settings.
// - Boost sense held low until settings done.
// - Start switching once boost sense reaches start.
// - Low optocurrent disables high-voltage charging.
// - Above high threshold: high off, gap, low on.
// - Below low threshold: low off, gap, high on.
// - Lower optocurrent widens the threshold gap.
// - Optocurrent regulated to fixed low target.
// - Gap ramps up from resistor-set start value.
module rssc_ctrl
  import rssc_pkg::*;
#(
  parameter int unsigned NOVL = NOVL_CYC  // Non-overlap cycles
) (
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst_b,
  // Analog comparator levels
  input  wire rssc_supply_t        supply,
  input  wire logic                boost_start_ok,
  input  wire logic                opto_below_reg,
  input  wire logic                cap_above_high,
  input  wire logic                cap_below_low,
  input  wire logic                protect_req,
  input  wire logic                burst_idle,
  // Optocurrent error: high means current above target
  input  wire logic                opto_above_target,
  // Settings readout converter results
  input  wire logic [SET_W-1:0]    settings_sense,
  input  wire logic [SET_W-1:0]    output_sense,
  input  wire logic [SET_W-1:0]    low_gate_sense,
  // High-voltage start-up controls
  output logic                     hv_limit_on,
  output logic                     hv_switch_on,
  // Boost sense pin, open drain: oe low while pulling low
  output logic                     boost_sense_pfc_ctrl_o,
  output logic                     boost_sense_pfc_ctrl_oe_b,
  // Gate drives
  output logic                     high_gate_drive,
  output logic                     low_gate_drive,
  // Threshold gap, opto bias trim, held settings and sequencer state
  output logic [DELTA_W-1:0]       cap_gap,
  output logic                     opto_bias_up,
  output rssc_settings_t           settings,
  output rssc_state_t              seq_state
);

  // ==========================================================
  // Sequencer state
  // ==========================================================
  rssc_state_t    state_reg, state_next;    // Sequencer state
  logic [7:0]     rd_cnt_reg, rd_cnt_next;  // Readout timer
  rssc_settings_t set_reg, set_next;        // Held settings
  logic           reg_up_reg, reg_up_next;  // Driver supply has come up
  logic           sw_reg, sw_next;          // Hysteretic switch state
  logic           lim_reg, lim_next;        // Current limit active
  logic           pull_reg, pull_next;      // Boost pin pulled low

  // Supply fault: either rail below its stop level
  logic supply_fail;
  assign supply_fail = supply.aux_below_stop | supply.reg_below_stop;

  // Start-level hysteresis: off above start, on below start plus hysteresis
  function automatic logic hyst_sw(logic cur, rssc_supply_t s);
    return s.aux_above_start ? 1'b0 : (s.aux_below_hyst ? 1'b1 : cur);
  endfunction

  // Next-state logic for sequencing and start-up switch
  always_comb begin
    state_next  = state_reg;
    rd_cnt_next = rd_cnt_reg;
    set_next    = set_reg;
    reg_up_next = reg_up_reg | supply.reg_above_uvp;
    sw_next     = sw_reg;
    lim_next    = ~supply.aux_above_rst;
    pull_next   = 1'b0;
    case (state_reg)
      RSSC_NO_SUPPLY: begin
        // Recharge both rails; nothing switches yet
        pull_next   = 1'b1;
        rd_cnt_next = 8'h00;
        if (!supply.aux_above_rst) begin
          sw_next = 1'b1;
        end else begin
          sw_next = hyst_sw(sw_reg, supply);
        end
        if (supply.aux_above_start && supply.reg_above_uvp) begin
          state_next = RSSC_READOUT;
        end
      end
      RSSC_READOUT: begin
        pull_next   = 1'b1;
        rd_cnt_next = rd_cnt_reg + 8'h01;
        sw_next     = hyst_sw(sw_reg, supply);
        if (rd_cnt_reg == 8'(READ_CYC - 1)) begin
          // Capture once; kept through no-supply until the next readout
          set_next.set_code  = settings_sense;
          set_next.out_code  = output_sense;
          set_next.start_gap = low_gate_sense;
          state_next         = RSSC_WAIT_BOOST;
        end
      end
      RSSC_WAIT_BOOST: begin
        sw_next = hyst_sw(sw_reg, supply);
        if (boost_start_ok && supply.reg_above_uvp) begin
          state_next = RSSC_RUN;
        end
      end
      RSSC_RUN: begin
        // Aux winding supplies; charge only in burst idle
        if (opto_below_reg) begin
          sw_next = 1'b0;
        end else if (burst_idle && supply.aux_below_low) begin
          sw_next = 1'b1;
        end else if (supply.aux_above_lowhys || !burst_idle) begin
          sw_next = 1'b0;
        end
        if (protect_req) begin
          state_next = RSSC_PROTECT;
        end
      end
      RSSC_PROTECT: begin
        sw_next = hyst_sw(sw_reg, supply);
      end
      default: state_next = RSSC_NO_SUPPLY;
    endcase
    // Rail loss overrides everything and restarts
    if (supply_fail || (reg_up_reg && !supply.reg_above_uvp &&
        state_reg == RSSC_RUN)) begin
      state_next  = RSSC_NO_SUPPLY;
      reg_up_next = 1'b0;
      pull_next   = 1'b1;
    end
  end

  // Sequencer registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg  <= RSSC_NO_SUPPLY;
      rd_cnt_reg <= 8'h00;
      set_reg    <= '0;
      reg_up_reg <= 1'b0;
      sw_reg     <= 1'b0;
      lim_reg    <= 1'b1;
      pull_reg   <= 1'b1;
    end else begin
      state_reg  <= state_next;
      rd_cnt_reg <= rd_cnt_next;
      set_reg    <= set_next;
      reg_up_reg <= reg_up_next;
      sw_reg     <= sw_next;
      lim_reg    <= lim_next;
      pull_reg   <= pull_next;
    end
  end

  // ==========================================================
  // Half-bridge switching and soft start
  // ==========================================================
  rssc_phase_t      ph_reg, ph_next;        // Gate phase
  logic [7:0]       nov_reg, nov_next;      // Non-overlap timer
  logic [DELTA_W-1:0] gap_reg, gap_next;    // Threshold gap
  logic [7:0]       rmp_reg, rmp_next;      // Ramp step timer
  logic             bias_reg, bias_next;    // Opto bias trim
  logic             hg_reg, hg_next;        // High gate drive flop
  logic             lg_reg, lg_next;        // Low gate drive flop
  logic             run;

  assign run = (state_reg == RSSC_RUN);

  // Gate phase, gap ramp and opto bias next values
  always_comb begin
    ph_next   = ph_reg;
    nov_next  = 8'h00;
    gap_next  = gap_reg;
    rmp_next  = rmp_reg + 8'h01;
    bias_next = opto_above_target;
    if (!run) begin
      // Idle: low side on keeps bootstrap charged; gap at start
      ph_next  = RSSC_LOW_ON;
      gap_next = {{(DELTA_W-SET_W){1'b0}}, set_reg.start_gap};
      rmp_next = 8'h00;
    end else begin
      case (ph_reg)
        RSSC_HIGH_ON: if (cap_above_high) ph_next = RSSC_GAP_TO_LOW;
        RSSC_GAP_TO_LOW: begin
          nov_next = nov_reg + 8'h01;
          if (nov_reg == 8'(NOVL - 1)) ph_next = RSSC_LOW_ON;
        end
        RSSC_LOW_ON: if (cap_below_low) ph_next = RSSC_GAP_TO_HIGH;
        RSSC_GAP_TO_HIGH: begin
          nov_next = nov_reg + 8'h01;
          if (nov_reg == 8'(NOVL - 1)) ph_next = RSSC_HIGH_ON;
        end
        default: ph_next = RSSC_LOW_ON;
      endcase
      // Gap follows loop: low optocurrent widens, high narrows
      if (rmp_reg == 8'(RAMP_STEP_CYC - 1)) begin
        rmp_next = 8'h00;
        if (!opto_above_target && gap_reg != '1) begin
          gap_next = gap_reg + GAP_STEP;
        end else if (opto_above_target && gap_reg != GAP_ZERO) begin
          gap_next = gap_reg - GAP_STEP;
        end
      end
    end
    // Decode from next phase so the gate pins leave a flip-flop directly
    hg_next = (ph_next == RSSC_HIGH_ON);
    lg_next = (ph_next == RSSC_LOW_ON);
  end

  // Switching registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ph_reg   <= RSSC_LOW_ON;
      nov_reg  <= 8'h00;
      gap_reg  <= GAP_ZERO;
      rmp_reg  <= 8'h00;
      bias_reg <= 1'b0;
      hg_reg   <= 1'b0;
      lg_reg   <= 1'b1;
    end else begin
      ph_reg   <= ph_next;
      nov_reg  <= nov_next;
      gap_reg  <= gap_next;
      rmp_reg  <= rmp_next;
      bias_reg <= bias_next;
      hg_reg   <= hg_next;
      lg_reg   <= lg_next;
    end
  end

  // ==========================================================
  // Outputs, all from flip-flops except the constant boost_sense_pfc_ctrl_o
  // ==========================================================
  assign hv_limit_on               = lim_reg;
  assign hv_switch_on              = sw_reg;
  assign boost_sense_pfc_ctrl_o    = 1'b0;
  assign boost_sense_pfc_ctrl_oe_b = ~pull_reg;
  assign high_gate_drive           = hg_reg;
  assign low_gate_drive            = lg_reg;
  assign cap_gap                   = gap_reg;
  assign opto_bias_up              = bias_reg;
  assign settings                  = set_reg;
  assign seq_state                 = state_reg;

  // ==========================================================
  // Checks
  // ==========================================================
  chk_gates_exclusive: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    !(high_gate_drive && low_gate_drive)) else $error("both gates on");
  chk_no_run_early: assert property (@(posedge ref_clk)
    disable iff (!rst_b) $rose(run) |-> $past(boost_start_ok))
    else $error("early run");
  chk_boost_pull: assert property (@(posedge ref_clk)
    disable iff (!rst_b) (state_reg == RSSC_READOUT) |=>
    !boost_sense_pfc_ctrl_oe_b) else $error("boost pin released");
  chk_fail_restart: assert property (@(posedge ref_clk)
    disable iff (!rst_b) supply_fail |=> state_reg == RSSC_NO_SUPPLY)
    else $error("no restart on fail");
  chk_high_to_low: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    (run && ph_reg == RSSC_HIGH_ON && cap_above_high) ##1 run [*2]
    |-> !high_gate_drive ##1 !low_gate_drive) else $error("bad high to low");
  chk_low_to_high: assert property (@(posedge ref_clk)
    disable iff (!rst_b) (run && ph_reg == RSSC_LOW_ON && cap_below_low)
    |=> !low_gate_drive) else $error("bad low to high");
  chk_opto_charge: assert property (@(posedge ref_clk)
    disable iff (!rst_b) (run && opto_below_reg && !supply_fail)
    |=> !hv_switch_on) else $error("charging near regulation");
  chk_limit_rst: assert property (@(posedge ref_clk)
    disable iff (!rst_b) !supply.aux_above_rst |=> hv_limit_on)
    else $error("no limit below reset");
  chk_hyst_off: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    (state_reg == RSSC_PROTECT && supply.aux_above_start && !supply_fail)
    |=> !hv_switch_on) else $error("switch on above start");
  chk_settings_hold: assert property (@(posedge ref_clk)
    disable iff (!rst_b) (state_reg == RSSC_RUN) |=> $stable(settings))
    else $error("settings changed");

endmodule

// ==== logic/rssc_pkg.sv ====
package rssc_pkg;
  // ==========================================================
  // Widths
  // ==========================================================
  localparam int unsigned SET_W   = 8;   // Readout code width
  localparam int unsigned DELTA_W = 10;  // Threshold gap width

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int unsigned CLK_NS        = 10;   // Clock period in ns
  localparam int unsigned NOVL_NS       = 100;  // Non-overlap delay, ns
  localparam int unsigned NOVL_CYC      = (NOVL_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RAMP_STEP_CYC = 16;   // Cycles per soft-start step
  localparam int unsigned READ_CYC      = 8;    // Settings readout length

  // ==========================================================
  // Supply sequencing states
  // ==========================================================
  typedef enum logic [2:0] {
    RSSC_NO_SUPPLY,
    RSSC_READOUT,
    RSSC_WAIT_BOOST,
    RSSC_RUN,
    RSSC_PROTECT
  } rssc_state_t;

  // Half-bridge gate phases
  typedef enum logic [1:0] {
    RSSC_LOW_ON,
    RSSC_GAP_TO_HIGH,
    RSSC_HIGH_ON,
    RSSC_GAP_TO_LOW
  } rssc_phase_t;

  // Supply comparator levels from the analog front end
  typedef struct packed {
    logic aux_above_rst;    // Aux supply above reset level
    logic aux_above_start;  // Aux supply above start level
    logic aux_below_hyst;   // Aux supply below start + hysteresis
    logic aux_below_low;    // Aux supply below low threshold
    logic aux_above_lowhys; // Aux supply above low + hysteresis
    logic aux_below_stop;   // Aux supply below stop level
    logic reg_above_uvp;    // Driver supply above undervoltage level
    logic reg_below_stop;   // Driver supply below stop level
  } rssc_supply_t;

  // Captured settings
  typedef struct packed {
    logic [SET_W-1:0] set_code;   // Settings pin code
    logic [SET_W-1:0] out_code;   // Output-sense pin code
    logic [SET_W-1:0] start_gap;  // Low-gate pin code: ramp start
  } rssc_settings_t;

  localparam logic [DELTA_W-1:0] GAP_ZERO = 10'h000;
  localparam logic [DELTA_W-1:0] GAP_STEP = 10'h001;
endpackage

// ==== sim/rssc_partner.sv ====
`timescale 1ns/1ps
// ==========================================================
// Far side: power-factor stage and resonant tank
// ==========================================================
module rssc_partner #(
  parameter int BOOST_DLY = 20  // Cycles for boost to reach start level
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_b,
  // Controller pins seen from outside
  input  wire logic boost_sense_pfc_ctrl_oe_b,
  input  wire logic high_gate_drive,
  input  wire logic low_gate_drive,
  // Analog levels back to the controller
  output logic      boost_start_ok,
  output logic      cap_above_high,
  output logic      cap_below_low
);
  logic [7:0] boost_reg;  // Boost voltage while released
  logic [7:0] cap_reg;    // Divided capacitor voltage
  // Boost collapses while pulled low, so a release restarts the climb
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      boost_reg <= 8'h00;
      cap_reg   <= 8'h00;
    end else begin
      if (!boost_sense_pfc_ctrl_oe_b)
        boost_reg <= 8'h00;
      else if (boost_reg < 8'hff)
        boost_reg <= boost_reg + 8'h01;
      // High side charges the tank, low side drains it
      if (high_gate_drive && cap_reg < 8'hff)
        cap_reg <= cap_reg + 8'h01;
      else if (low_gate_drive && cap_reg > 8'h00)
        cap_reg <= cap_reg - 8'h01;
    end
  end
  assign boost_start_ok = boost_reg >= 8'(BOOST_DLY);
  assign cap_above_high = cap_reg >= 8'h28;
  assign cap_below_low  = cap_reg <= 8'h08;
endmodule

// ==== sim/test_resonant_startup_and_vcap_switch_ctrl.sv ====
`timescale 1ns/1ps
module test_resonant_startup_and_vcap_switch_ctrl;
  import rssc_pkg::*;
  // ==========================================================
  // Signals
  // ==========================================================
  logic             ref_clk, rst_b, boost_ok, opto_reg, cap_hi, cap_lo;
  logic             prot, burst, opto_hi, hv_lim, hv_sw, bs_o, bs_oe_b;
  logic             hg, lg, bias_up;
  rssc_supply_t     sup;       // Supply comparator levels
  logic [SET_W-1:0] s_set, s_out, s_low;
  logic [DELTA_W-1:0] gap, g0;
  rssc_settings_t   set_q;
  rssc_state_t      st;
  int               fail_count, checked, cyc_cnt, n;

  rssc_ctrl dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .supply(sup),
    .boost_start_ok(boost_ok), .opto_below_reg(opto_reg),
    .cap_above_high(cap_hi), .cap_below_low(cap_lo), .protect_req(prot),
    .burst_idle(burst), .opto_above_target(opto_hi),
    .settings_sense(s_set), .output_sense(s_out), .low_gate_sense(s_low),
    .hv_limit_on(hv_lim), .hv_switch_on(hv_sw),
    .boost_sense_pfc_ctrl_o(bs_o), .boost_sense_pfc_ctrl_oe_b(bs_oe_b),
    .high_gate_drive(hg), .low_gate_drive(lg), .cap_gap(gap),
    .opto_bias_up(bias_up), .settings(set_q), .seq_state(st));
  rssc_partner p_u (.ref_clk(ref_clk), .rst_b(rst_b),
    .boost_sense_pfc_ctrl_oe_b(bs_oe_b), .high_gate_drive(hg),
    .low_gate_drive(lg), .boost_start_ok(boost_ok),
    .cap_above_high(cap_hi), .cap_below_low(cap_lo));

  // ==========================================================
  // Clock, timeout and checking helpers
  // ==========================================================
  always #5 ref_clk = ~ref_clk;
  // Whole run needs under 1000 cycles; generous ceiling
  always @(posedge ref_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic chk1(string nm, logic e, logic g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chkv(string nm, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Land after the edge so registered outputs have settled
  task automatic tick(int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic wait_st(rssc_state_t s);
    int i;
    i = 0;
    while (st !== s && i < 200) begin
      tick(1);
      i++;
    end
    chkv("seq_state", s, st);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_power_up();
    chk1("hv_limit_on", 1'b1, hv_lim);
    chk1("boost oe_b", 1'b0, bs_oe_b);
    chk1("boost out", 1'b0, bs_o);
    chk1("high gate", 1'b0, hg);
    @(posedge ref_clk) sup.aux_above_rst <= 1'b1;
    tick(2);
    chk1("hv_limit_on", 1'b0, hv_lim);
    chk1("hv_switch_on", 1'b1, hv_sw);
    // Aux at start but driver supply still low: must not leave
    @(posedge ref_clk) sup.aux_above_start <= 1'b1;
    tick(6);
    chkv("seq_state", RSSC_NO_SUPPLY, st);
    chk1("hv_switch_on", 1'b0, hv_sw);
  endtask
  task automatic t_readout(logic [23:0] codes);
    @(posedge ref_clk) sup.reg_above_uvp <= 1'b1;
    wait_st(RSSC_READOUT);
    n = 0;
    while (st === RSSC_READOUT && n < 50) begin
      chk1("boost oe_b", 1'b0, bs_oe_b);
      tick(1);
      n++;
    end
    chkv("readout cycles", READ_CYC, n);
    chkv("settings", codes, set_q);
    tick(2);
    chk1("boost oe_b", 1'b1, bs_oe_b);
    chkv("seq_state", RSSC_WAIT_BOOST, st);
    chk1("high gate", 1'b0, hg);
    wait_st(RSSC_RUN);
    chk1("boost_start_ok", 1'b1, boost_ok);
    chkv("cap_gap start", {2'b00, s_low}, gap);
  endtask
  // Counts the dead time between one gate dropping and the other rising
  task automatic t_gate_edge(logic to_high);
    n = 0;
    while ((to_high ? lg : hg) === 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    n = 0;
    while ((to_high ? hg : lg) !== 1'b1 && n < 50) begin
      chk1("both gates off", 1'b0, hg | lg);
      tick(1);
      n++;
    end
    chkv("non-overlap", NOVL_CYC, n);
  endtask
  task automatic t_gap_loop();
    tick(40);
    g0 = gap;
    chk1("gap ramps up", 1'b1, g0 > {2'b00, s_low});
    @(posedge ref_clk) opto_hi <= 1'b1;
    tick(2);
    chk1("opto_bias_up", 1'b1, bias_up);
    tick(40);
    chk1("gap narrows", 1'b1, gap < g0);
    @(posedge ref_clk) opto_hi <= 1'b0;
    tick(2);
    chk1("opto_bias_up", 1'b0, bias_up);
  endtask
  // Hysteretic charge: on below lower edge, hold in band, off above
  task automatic t_hyst(logic on_lvl, logic off_lvl);
    tick(2);
    chk1("hv_switch_on low", 1'b1, hv_sw);
    @(posedge ref_clk) begin
      sup.aux_below_low  <= 1'b0;
      sup.aux_below_hyst <= 1'b0;
    end
    tick(3);
    chk1("hv_switch_on band", 1'b1, hv_sw);
    @(posedge ref_clk) begin
      sup.aux_above_lowhys <= off_lvl;
      sup.aux_above_start  <= on_lvl;
    end
    tick(2);
    chk1("hv_switch_on high", 1'b0, hv_sw);
  endtask
  task automatic t_fail();
    @(posedge ref_clk) begin
      sup.reg_below_stop  <= 1'b1;
      sup.reg_above_uvp   <= 1'b0;
      sup.aux_above_start <= 1'b0;
      sup.aux_below_hyst  <= 1'b1;
      s_set               <= 8'ha5;
    end
    wait_st(RSSC_NO_SUPPLY);
    chk1("boost oe_b", 1'b0, bs_oe_b);
    tick(4);
    chk1("hv_switch_on", 1'b1, hv_sw);
    chkv("settings held", 24'h5a3c11, set_q);
    @(posedge ref_clk) begin
      sup.reg_below_stop  <= 1'b0;
      sup.aux_below_hyst  <= 1'b0;
      sup.aux_above_start <= 1'b1;
    end
  endtask

  // Near regulation charging stops; driver rail loss in RUN restarts
  task automatic t_run_loss();
    @(posedge ref_clk) begin
      burst                <= 1'b1;
      sup.aux_below_low    <= 1'b1;
      sup.aux_above_lowhys <= 1'b0;
    end
    tick(2);
    chk1("hv_switch_on burst", 1'b1, hv_sw);
    @(posedge ref_clk) opto_reg <= 1'b1;
    tick(2);
    chk1("hv_switch_on opto", 1'b0, hv_sw);
    @(posedge ref_clk) sup.reg_above_uvp <= 1'b0;
    wait_st(RSSC_NO_SUPPLY);
    tick(1);
    chk1("high gate", 1'b0, hg);
  endtask

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    {ref_clk, rst_b, opto_reg, prot, burst, opto_hi} = '0;
    sup = '0;
    {s_set, s_out, s_low} = 24'h5a3c11;
    {fail_count, checked, cyc_cnt} = '0;
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    tick(1);
    t_power_up();
    t_readout(24'h5a3c11);
    t_gate_edge(1'b1);
    t_gate_edge(1'b0);
    t_gap_loop();
    @(posedge ref_clk) begin
      burst <= 1'b1;
      sup.aux_above_start <= 1'b0;
      sup.aux_below_low <= 1'b1;
    end
    t_hyst(1'b0, 1'b1);
    @(posedge ref_clk) begin
      burst <= 1'b0;
      prot <= 1'b1;
    end
    wait_st(RSSC_PROTECT);
    @(posedge ref_clk) sup.aux_below_hyst <= 1'b1;
    t_hyst(1'b1, 1'b1);
    @(posedge ref_clk) prot <= 1'b0;
    t_fail();
    t_readout(24'ha53c11);
    t_run_loss();
    complete_run();
  end
endmodule
